/* verilog/lbst_pkg.sv */
// Purpose: shared constants and types for the local bus strobe timing block
// Assumes: one clock domain, the host bus clock
// Notes:   the field struct mirrors the bit layout of the lower timing register
package lbst_pkg;

    // byte offset of the lower timing register in the local register space
    localparam logic [7:0] LBST_LT1_OFFSET = 8'h08;

    // clocks from the host master's ready assertion to the reference cycle
    localparam int unsigned LBST_REF_DELAY = 2;

    // width of one timing count
    localparam int unsigned LBST_CNT_W = 4;

    // one timing count
    typedef logic [LBST_CNT_W-1:0] lbst_cnt_t;

    // register layout, msb first: bits 31:28 down to 3:0
    typedef struct packed {
        lbst_cnt_t wr_off;   // write strobe release / data strobe release on write
        lbst_cnt_t wr_on;    // write strobe assert / data strobe assert on write
        lbst_cnt_t rd_off;   // read strobe release / data strobe release on read
        lbst_cnt_t rd_on;    // read strobe assert / data strobe assert on read
        lbst_cnt_t wcs_off;  // write chip select release / read-not-write release
        lbst_cnt_t wcs_on;   // write chip select assert
        lbst_cnt_t rcs_off;  // read chip select release
        lbst_cnt_t rcs_on;   // read chip select assert
    } lbst_fields_t;

    // values after reset, local bus personality
    localparam lbst_fields_t LBST_RESET_BUS = '{
        wr_off: 4'h2, wr_on: 4'h0, rd_off: 4'h3, rd_on: 4'h0,
        wcs_off: 4'h2, wcs_on: 4'h0, rcs_off: 4'h3, rcs_on: 4'h0};

    // values after reset, parallel port personality
    localparam lbst_fields_t LBST_RESET_PAR = '{
        wr_off: 4'h2, wr_on: 4'h1, rd_off: 4'h2, rd_on: 4'h1,
        wcs_off: 4'h2, wcs_on: 4'h0, rcs_off: 4'h2, rcs_on: 4'h0};

    // access sequencer states
    typedef enum logic [1:0] {
        LBST_IDLE,
        LBST_PRE,
        LBST_RUN,
        LBST_DONE
    } lbst_state_t;

endpackage

/* verilog/lbst_strobe.sv */
// Purpose: one active-low local bus strobe with programmed assert/release counts
// Assumes: count_next_in rises by one each clock while run_next_in is high
// Notes:   works on next-cycle values so the pin changes in the counted cycle
`timescale 1ns/1ps
module lbst_strobe (
    input  wire logic             clock_in,
    input  wire logic             rst_n_in,
    input  wire logic             run_next_in,
    input  wire logic             enable_in,
    input  wire lbst_pkg::lbst_cnt_t count_next_in,
    input  wire lbst_pkg::lbst_cnt_t on_in,
    input  wire lbst_pkg::lbst_cnt_t off_in,
    output logic                  strobe_n_out
);

    logic strobe_n_reg;   // pin level, low means asserted
    logic strobe_n_next;  // level for the coming cycle
    wire  active;         // access running and this strobe in use
    wire  hit_on;         // coming cycle is the assert count
    wire  hit_off;        // coming cycle is the release count

    assign active  = run_next_in && enable_in;
    // one assert per access
    // an assert count not below the release count leaves the strobe high all access,
    // otherwise it would fall late and stick low until the access ends
    assign hit_on  = active && (count_next_in == on_in) && (on_in < off_in);
    assign hit_off = active && (count_next_in == off_in);

    // the counter never revisits a value, so each edge happens once per access
    // release wins if both counts are equal, keeping the pin from sticking low
    assign strobe_n_next = !active ? 1'b1 :
                           hit_off ? 1'b1 :
                           hit_on  ? 1'b0 : strobe_n_reg;

    // strobe level register
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strobe_n_reg <= 1'b1;
        end else begin
            strobe_n_reg <= strobe_n_next;
        end
    end

    assign strobe_n_out = strobe_n_reg;

endmodule

/* verilog/lbst_timing.sv */
// Purpose: sequences local bus strobes for function 1 base region accesses
// Assumes: host holds the access request and hit until ready is seen
// Notes:   counts above ten are not defended; the counter saturates at 15
`timescale 1ns/1ps
module lbst_timing (
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    input  wire logic        parallel_port_in,
    input  wire logic        data_strobe_style_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [3:0]  reg_be_in,
    input  wire logic [31:0] reg_wdata_in,
    output logic      [31:0] reg_rdata_out,
    input  wire logic [1:0]  access_bar_hit_in,
    input  wire logic        irdy_n_in,
    input  wire logic        access_write_in,
    input  wire logic [7:0]  access_wdata_in,
    output logic             access_ready_out,
    output logic      [7:0]  access_rdata_out,
    input  wire logic [7:0]  lb_data_in,
    output logic      [7:0]  lb_data_out,
    output logic             lb_data_oe_out,
    output logic      [3:0]  lb_chip_selects_n_out,
    output logic             lb_read_strobe_n_out,
    output logic             lb_write_strobe_n_out,
    output logic      [3:0]  lb_data_strobes_n_out,
    output logic             lb_read_not_write_out
);

    // larger of two counts, used for the end of read and write accesses
    function automatic lbst_pkg::lbst_cnt_t cnt_max(input lbst_pkg::lbst_cnt_t a,
                                                    input lbst_pkg::lbst_cnt_t b);
        cnt_max = (a > b) ? a : b;
    endfunction

    logic [31:0]           lt1_reg;        // lower timing register
    logic                  strap_done_reg; // reset values loaded from strap
    lbst_pkg::lbst_state_t state_reg;      // sequencer state
    lbst_pkg::lbst_state_t state_next;
    lbst_pkg::lbst_cnt_t   cnt_reg;        // clocks since reference cycle
    lbst_pkg::lbst_cnt_t   cnt_next;
    lbst_pkg::lbst_cnt_t   pre_reg;        // clocks since master ready
    logic                  write_reg;      // access direction, latched
    logic                  style_reg;      // strobe style, latched per access
    logic [7:0]            rdata_reg;      // captured read data
    logic [7:0]            wdata_reg;      // write data to the local bus
    logic                  oe_reg;         // local data bus drive
    logic [31:0]           rdata_bus_reg;  // register read data
    lbst_pkg::lbst_fields_t f;             // register as named counts
    lbst_pkg::lbst_cnt_t   last;           // final edge count of this access
    lbst_pkg::lbst_cnt_t   cs_on, cs_off, ds_on, ds_off;
    logic                  cs_n, ds_n;
    wire                   start;          // new access seen
    wire                   run_next;
    wire                   lt1_sel;
    wire                   capture;
    wire [31:0]            wmask;

    assign f = lbst_pkg::lbst_fields_t'(lt1_reg);

    assign start = (state_reg == lbst_pkg::LBST_IDLE) && (|access_bar_hit_in) && !irdy_n_in;

    assign last = write_reg ? cnt_max(f.wcs_off, f.wr_off) :
                  style_reg ? f.rd_off : cnt_max(f.rcs_off, f.rd_off);

    // next state: reference cycle is entered after the pre-count
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            lbst_pkg::LBST_IDLE: if (start) state_next = lbst_pkg::LBST_PRE;
            lbst_pkg::LBST_PRE:
                if (pre_reg == lbst_pkg::lbst_cnt_t'(lbst_pkg::LBST_REF_DELAY - 1))
                    state_next = lbst_pkg::LBST_RUN;
            lbst_pkg::LBST_RUN:  if (cnt_reg >= last) state_next = lbst_pkg::LBST_DONE;
            lbst_pkg::LBST_DONE: state_next = lbst_pkg::LBST_IDLE;
            default:             state_next = lbst_pkg::LBST_IDLE;
        endcase
    end

    assign run_next = (state_next == lbst_pkg::LBST_RUN);
    // counter starts at zero in the reference cycle, saturates to stay monotonic
    assign cnt_next = (state_reg != lbst_pkg::LBST_RUN) ? '0 :
                      (&cnt_reg) ? cnt_reg : cnt_reg + 4'h1;

    // sequencer registers
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= lbst_pkg::LBST_IDLE;
            cnt_reg   <= '0;
            pre_reg   <= '0;
            write_reg <= 1'b0;
            style_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= run_next ? cnt_next : '0;
            pre_reg   <= (state_reg == lbst_pkg::LBST_PRE) ? pre_reg + 4'h1 : 4'h1;
            if (start) begin
                write_reg <= access_write_in;
                style_reg <= data_strobe_style_in;
            end
        end
    end

    // read data is taken on the edge where the read strobe releases
    assign capture = run_next && !write_reg && (cnt_next == f.rd_off);

    // local data path; write data is driven for the whole access
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_reg <= '0;
            wdata_reg <= '0;
            oe_reg    <= 1'b0;
        end else begin
            if (capture) rdata_reg <= lb_data_in;
            if (start) wdata_reg <= access_wdata_in;
            // take the new direction at the start edge, so a read never drives the bus
            oe_reg <= (start ? access_write_in : write_reg) &&
                      (state_next == lbst_pkg::LBST_RUN || state_next == lbst_pkg::LBST_PRE);
        end
    end

    // register port: byte-lane writes, unmapped reads return zero
    assign lt1_sel = (reg_addr_in == lbst_pkg::LBST_LT1_OFFSET);
    assign wmask   = {{8{reg_be_in[3]}}, {8{reg_be_in[2]}}, {8{reg_be_in[1]}}, {8{reg_be_in[0]}}};

    // reset values depend on the strap, so they load on the first clock after release
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lt1_reg        <= lbst_pkg::LBST_RESET_BUS;
            strap_done_reg <= 1'b0;
            rdata_bus_reg  <= '0;
        end else begin
            strap_done_reg <= 1'b1;
            if (!strap_done_reg)
                lt1_reg <= parallel_port_in ? lbst_pkg::LBST_RESET_PAR : lbst_pkg::LBST_RESET_BUS;
            else if (reg_wr_in && lt1_sel)
                lt1_reg <= (lt1_reg & ~wmask) | (reg_wdata_in & wmask);
            if (reg_rd_in) rdata_bus_reg <= lt1_sel ? lt1_reg : '0;
        end
    end

    assign cs_on  = write_reg ? f.wcs_on  : f.rcs_on;
    assign cs_off = write_reg ? f.wcs_off : f.rcs_off;
    assign ds_on  = write_reg ? f.wr_on   : f.rd_on;
    assign ds_off = write_reg ? f.wr_off  : f.rd_off;

    // chip selects only in separate style
    lbst_strobe u_cs (.clock_in(clock_in), .rst_n_in(rst_n_in), .run_next_in(run_next),
        .enable_in(!style_reg), .count_next_in(cnt_next), .on_in(cs_on), .off_in(cs_off),
        .strobe_n_out(cs_n));
    lbst_strobe u_rd (.clock_in(clock_in), .rst_n_in(rst_n_in), .run_next_in(run_next),
        .enable_in(!style_reg && !write_reg), .count_next_in(cnt_next), .on_in(f.rd_on),
        .off_in(f.rd_off), .strobe_n_out(lb_read_strobe_n_out));
    lbst_strobe u_wr (.clock_in(clock_in), .rst_n_in(rst_n_in), .run_next_in(run_next),
        .enable_in(!style_reg && write_reg), .count_next_in(cnt_next), .on_in(f.wr_on),
        .off_in(f.wr_off), .strobe_n_out(lb_write_strobe_n_out));
    lbst_strobe u_ds (.clock_in(clock_in), .rst_n_in(rst_n_in), .run_next_in(run_next),
        .enable_in(style_reg), .count_next_in(cnt_next), .on_in(ds_on), .off_in(ds_off),
        .strobe_n_out(ds_n));
    // rnw low from reference on data-strobe style writes
    lbst_strobe u_rnw (.clock_in(clock_in), .rst_n_in(rst_n_in), .run_next_in(run_next),
        .enable_in(style_reg && write_reg), .count_next_in(cnt_next), .on_in(4'h0),
        .off_in(f.wcs_off), .strobe_n_out(lb_read_not_write_out));

    // all four selects and data strobes move together
    assign lb_chip_selects_n_out = {4{cs_n}};
    assign lb_data_strobes_n_out = {4{ds_n}};
    assign access_ready_out      = (state_reg == lbst_pkg::LBST_DONE);
    assign access_rdata_out      = rdata_reg;
    assign lb_data_out           = wdata_reg;
    assign lb_data_oe_out        = oe_reg;
    assign reg_rdata_out         = rdata_bus_reg;

    // checks; all in the host clock domain
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    wire sep_rd = (state_reg == lbst_pkg::LBST_RUN) && !style_reg && !write_reg;
    wire sep_wr = (state_reg == lbst_pkg::LBST_RUN) && !style_reg && write_reg;

    ref_delay_a: assert property (start |-> ##2
        (state_reg == lbst_pkg::LBST_RUN && cnt_reg == 0))
        else $error("reference cycle not two clocks after master ready");
    rcs_assert_a: assert property (sep_rd && cnt_reg == f.rcs_on && f.rcs_on < f.rcs_off
        |-> lb_chip_selects_n_out == 4'h0)
        else $error("read chip selects not low at their count");
    rcs_release_a: assert property (sep_rd && cnt_reg == f.rcs_off && cnt_reg != 0
        && f.rcs_on < f.rcs_off
        |-> lb_chip_selects_n_out == 4'hf && $past(lb_chip_selects_n_out) == 4'h0)
        else $error("read chip selects not released at their count");
    wcs_assert_a: assert property (sep_wr && cnt_reg == f.wcs_on && f.wcs_on < f.wcs_off
        |-> lb_chip_selects_n_out == 4'h0)
        else $error("write chip selects not low at their count");
    rnw_release_a: assert property (style_reg && write_reg
        && state_reg == lbst_pkg::LBST_RUN && cnt_reg < f.wcs_off |-> !lb_read_not_write_out)
        else $error("read-not-write high too early on a write");
    ds_no_cs_a: assert property (style_reg && state_reg != lbst_pkg::LBST_IDLE
        |-> lb_chip_selects_n_out == 4'hf)
        else $error("chip selects moved in data-strobe style");
    rd_assert_a: assert property (sep_rd && cnt_reg == f.rd_on && f.rd_on < f.rd_off
        |-> !lb_read_strobe_n_out ##1 (cnt_reg >= f.rd_off || !lb_read_strobe_n_out))
        else $error("read strobe not low at its count");
    wait_hold_a: assert property (start |-> !access_ready_out [*3])
        else $error("host released before the reference cycle");
    strobe_stable_a: assert property (sep_rd && cnt_reg != 0 && cnt_reg != f.rd_on
        && cnt_reg != f.rd_off |-> $stable(lb_read_strobe_n_out))
        else $error("read strobe moved off its counts");

    read_done_c: cover property (sep_rd ##1 access_ready_out);
    write_done_c: cover property (sep_wr ##1 access_ready_out);
    ds_write_c: cover property (style_reg && write_reg && access_ready_out);

endmodule

/* tb/lbst_periph.sv */
// Purpose: behavioural 8-bit peripheral on the far side of the local bus
// Assumes: it answers reads while selected, and takes writes on a strobe rising edge
// Notes:   a released data bus shows the inverse of the last byte, so a stale byte
//          can never pass as a good read
`timescale 1ns/1ps
module lbst_periph (
    input  wire logic       clock_in,             // host bus clock
    input  wire logic [7:0] rd_byte_in,           // byte to return on reads
    input  wire logic [3:0] lb_chip_selects_n_in, // selects from the block
    input  wire logic       lb_read_strobe_n_in,  // separate read strobe
    input  wire logic       lb_write_strobe_n_in, // separate write strobe
    input  wire logic [3:0] lb_data_strobes_n_in, // data strobes
    input  wire logic       lb_read_not_write_in, // direction in data-strobe style
    input  wire logic       lb_data_oe_in,        // block drives the data bus
    input  wire logic [7:0] lb_wdata_in,          // data bus as driven by the block
    output logic      [7:0] lb_rdata_out,         // data bus as driven by us
    output logic      [7:0] wr_byte_out           // byte taken by the last write
);
    logic [7:0] last_q = 8'h00; // last byte put on the bus
    logic       wr_q   = 1'b1;  // write strobe one cycle back
    logic       ds_q   = 1'b1;  // data strobe one cycle back
    logic       rnw_q  = 1'b1;  // direction one cycle back
    logic       drive;          // we own the data bus
    initial wr_byte_out = 8'h00;
    // answer only while selected for a read, in either strobe style
    assign drive = (lb_chip_selects_n_in == 4'h0 && !lb_read_strobe_n_in)
                || (lb_data_strobes_n_in == 4'h0 && lb_read_not_write_in);
    assign lb_rdata_out = drive ? rd_byte_in : ~last_q;
    // take write data where the strobe rises; an undriven bus gives unknown data
    always @(posedge clock_in) begin
        wr_q <= lb_write_strobe_n_in;
        ds_q <= lb_data_strobes_n_in[0];
        rnw_q <= lb_read_not_write_in;
        if (drive)
            last_q <= rd_byte_in;
        if ((!wr_q && lb_write_strobe_n_in) || (!ds_q && lb_data_strobes_n_in[0] && !rnw_q))
            wr_byte_out <= lb_data_oe_in ? lb_wdata_in : 8'hxx;
    end
endmodule

/* tb/testbench.sv */
// Purpose: self-checking bench for the local bus strobe timing block
// Assumes: inputs change by non-blocking assignment at rising clock edges
// Notes:   every strobe level is compared in every cycle after the request of each run_row access; the mid-write reset access in cycle 3 and under reset
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("BAD %0t got %h exp %h", $time, (got), (exp)); \
    end \
end
module testbench;
    typedef struct packed {
        logic [31:0] val;  // timing register value
        logic        ds;   // data-strobe style
        logic        wr;   // write access
        logic [1:0]  hit;  // base region hit
        logic [7:0]  d;    // byte written or returned
        logic        prog; // program the register first
    } lbst_row_t;
    logic        clock_in = 1'b0, rst_n_in = 1'b0, parallel_port_in = 1'b0;
    logic        data_strobe_style_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic        irdy_n_in = 1'b1, access_write_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00, access_wdata_in = 8'h00, rd_byte = 8'h00;
    logic [3:0]  reg_be_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
    logic [1:0]  access_bar_hit_in = 2'h0;
    logic [7:0]  access_rdata_out, lb_data_in, lb_data_out, wr_byte;
    logic [3:0]  lb_chip_selects_n_out, lb_data_strobes_n_out;
    logic        access_ready_out, lb_data_oe_out, lb_read_strobe_n_out;
    logic        lb_write_strobe_n_out, lb_read_not_write_out;
    logic [11:0] outs; // all strobes plus ready, in the order exp_out builds
    int          error_cnt = 0;
    int          check_count = 0;
    // counts kept within zero to ten
    lbst_row_t rows [7] = '{
        '{32'h2030_2030, 1'b0, 1'b0, 2'h1, 8'ha5, 1'b1},
        '{32'h2030_2030, 1'b0, 1'b1, 2'h2, 8'h96, 1'b1},
        '{32'h3141_5792, 1'b1, 1'b0, 2'h1, 8'h3c, 1'b1},
        '{32'h3141_5792, 1'b1, 1'b1, 2'h2, 8'hc3, 1'b1},
        '{32'h3192_41a0, 1'b0, 1'b1, 2'h1, 8'h69, 1'b1},
        '{32'h3192_41a0, 1'b0, 1'b0, 2'h2, 8'h5a, 1'b1},
        '{32'h3192_41a0, 1'b0, 1'b1, 2'h1, 8'h87, 1'b0}};
    assign outs = {lb_chip_selects_n_out, lb_read_strobe_n_out, lb_write_strobe_n_out,
                   lb_data_strobes_n_out, lb_read_not_write_out, access_ready_out};
    lbst_timing dut (
        .clock_in, .rst_n_in, .parallel_port_in, .data_strobe_style_in, .reg_wr_in,
        .reg_rd_in, .reg_addr_in, .reg_be_in, .reg_wdata_in, .reg_rdata_out,
        .access_bar_hit_in, .irdy_n_in, .access_write_in, .access_wdata_in,
        .access_ready_out, .access_rdata_out, .lb_data_in, .lb_data_out, .lb_data_oe_out,
        .lb_chip_selects_n_out, .lb_read_strobe_n_out, .lb_write_strobe_n_out,
        .lb_data_strobes_n_out, .lb_read_not_write_out);
    lbst_periph peer (
        .clock_in, .rd_byte_in(rd_byte), .lb_chip_selects_n_in(lb_chip_selects_n_out),
        .lb_read_strobe_n_in(lb_read_strobe_n_out), .lb_write_strobe_n_in(lb_write_strobe_n_out),
        .lb_data_strobes_n_in(lb_data_strobes_n_out), .lb_data_oe_in(lb_data_oe_out),
        .lb_read_not_write_in(lb_read_not_write_out), .lb_wdata_in(lb_data_out),
        .lb_rdata_out(lb_data_in), .wr_byte_out(wr_byte));
    // 200 MHz clock
    always #2.5 clock_in = ~clock_in;
    // strobe low from its assert count until its release count; equal counts never low
    function automatic logic act(int on, int off, int t);
        return t >= on && t < off;
    endfunction
    // count of the last edge of an access, after which ready follows
    function automatic int done_at(lbst_pkg::lbst_fields_t f, logic ds, logic wr);
        if (wr)
            return (f.wcs_off > f.wr_off) ? f.wcs_off : f.wr_off;
        if (ds)
            return f.rd_off;
        return (f.rcs_off > f.rd_off) ? f.rcs_off : f.rd_off;
    endfunction
    // expected strobes and ready in cycle k, counted from the request cycle
    function automatic logic [11:0] exp_out(lbst_pkg::lbst_fields_t f, logic ds, logic wr, int k);
        int         t;
        logic [3:0] cs;
        logic [3:0] dsn;
        logic       rd;
        logic       wn;
        logic       rnw;
        t = k - 2;
        cs = {4{!(!ds && (wr ? act(f.wcs_on, f.wcs_off, t) : act(f.rcs_on, f.rcs_off, t)))}};
        rd = !(!ds && !wr && act(f.rd_on, f.rd_off, t));
        wn = !(!ds && wr && act(f.wr_on, f.wr_off, t));
        dsn = {4{!(ds && (wr ? act(f.wr_on, f.wr_off, t) : act(f.rd_on, f.rd_off, t)))}};
        rnw = !(ds && wr && act(0, f.wcs_off, t));
        return {cs, rd, wn, dsn, rnw, k == 3 + done_at(f, ds, wr)};
    endfunction
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clock_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_be_in <= be;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        #1;
        `CHK(reg_rdata_out, exp)
    endtask
    // one access: request held until the edge that samples ready, then dropped
    task automatic run_row(input lbst_row_t r);
        int n;
        n = done_at(r.val, r.ds, r.wr);
        if (r.prog) begin
            reg_write(8'h08, r.val, 4'hf);
            reg_read(8'h08, r.val);
        end
        @(posedge clock_in);
        data_strobe_style_in <= r.ds;
        access_write_in <= r.wr;
        access_wdata_in <= r.d;
        rd_byte <= r.d;
        access_bar_hit_in <= r.hit;
        irdy_n_in <= 1'b0;
        for (int k = 1; k <= n + 4; k++) begin
            @(posedge clock_in);
            if (k == n + 4) begin
                irdy_n_in <= 1'b1;
                access_bar_hit_in <= 2'h0;
            end
            #1;
            `CHK(outs, exp_out(r.val, r.ds, r.wr, k))
            // data bus driven only on writes, from the start edge to the last edge
            `CHK(lb_data_oe_out, r.wr && k <= n + 2)
        end
        if (r.wr) `CHK(wr_byte, r.d)
        else `CHK(access_rdata_out, r.d)
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        #20000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        reg_read(8'h08, 32'h2030_2030);
        reg_read(8'h0c, 32'h0000_0000);
        reg_write(8'h0c, 32'hffff_ffff, 4'hf);
        reg_write(8'h08, 32'hffff_ffff, 4'h2);
        reg_read(8'h08, 32'h2030_ff30);
        foreach (rows[i]) run_row(rows[i]);
        // reset in mid-write must release every strobe at once
        @(posedge clock_in);
        irdy_n_in <= 1'b0;
        access_bar_hit_in <= 2'h1;
        repeat (3) @(posedge clock_in);
        #1;
        `CHK(outs, exp_out(32'h3192_41a0, 1'b0, 1'b1, 3))
        @(posedge clock_in);
        rst_n_in <= 1'b0;
        parallel_port_in <= 1'b1;
        irdy_n_in <= 1'b1;
        access_bar_hit_in <= 2'h0;
        #1;
        `CHK(outs, 12'hffe)
        repeat (3) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        reg_read(8'h08, 32'h2121_2020);
        run_row('{32'h2121_2020, 1'b0, 1'b0, 2'h1, 8'h3c, 1'b0});
        give_verdict();
    end
endmodule
